/* src/swc_pkg.sv */
// Constants, field layout and carrier types of the switch configuration bank.
// Assumes a single 100 MHz clock and a 16-bit serial EEPROM with 6-bit word addresses.
package swc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Word addresses and signature
    localparam logic [5:0] SWC_ADDR_SIG = 6'h00;
    localparam logic [5:0] SWC_ADDR_CTRL_ONE = 6'h02;
    localparam logic [5:0] SWC_ADDR_CTRL_TWO = 6'h03;
    localparam logic [5:0] SWC_ADDR_XCVR = 6'h04;
    localparam logic [15:0] SWC_SIGNATURE = 16'h55AA;
    localparam logic [2:0] SWC_READ_CMD = 3'h6;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int SWC_STORM_BIT = 2;
    localparam int SWC_DUPLEX_BIT = 12;
    localparam int SWC_RATE_BIT = 11;
    localparam int SWC_PAUSE_BIT = 10;
    localparam int SWC_PORT_ON_BIT = 9;
    localparam int SWC_DISCARD_BIT = 7;
    localparam int SWC_HASH_LSB = 5;
    localparam int SWC_AGE_LSB = 3;
    localparam int SWC_FWD_ALL_BIT = 2;
    localparam int SWC_BACKOFF_BIT = 1;
    localparam int SWC_ODD_LSB = 14;
    localparam int SWC_EVEN_LSB = 12;
    localparam int SWC_FORCE_BIT = 11;
    localparam int SWC_FEF_BIT = 10;
    localparam int SWC_SAVE_PW_BIT = 9;
    localparam int SWC_XOVER_BIT = 8;

    // Implemented bits; reserved bits always read as zero
    localparam logic [15:0] SWC_CTRL_ONE_MASK = 16'h0004;
    localparam logic [15:0] SWC_CTRL_TWO_MASK = 16'h1EFE;
    localparam logic [15:0] SWC_XCVR_MASK = 16'hFF00;

    localparam logic [15:0] SWC_CTRL_ONE_RST = 16'h0000;
    localparam logic [15:0] SWC_CTRL_TWO_RST = 16'h1812;
    localparam logic [15:0] SWC_XCVR_RST = 16'h0600;

    localparam logic [1:0] SWC_HASH_CRC_CRC = 2'h2;
    localparam logic [1:0] SWC_AGE_NONE = 2'h0;
    localparam logic [1:0] SWC_OPT_NWAY = 2'h0;
    localparam logic [1:0] SWC_OPT_FX_FULL = 2'h2;
    localparam logic [1:0] SWC_OPT_FX_HALF = 2'h3;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int SWC_CLK_PERIOD_NS = 10;
    localparam int SWC_SK_HALF_NS = 500;
    localparam int SWC_SK_HALF_CYC = (SWC_SK_HALF_NS + SWC_CLK_PERIOD_NS - 1) / SWC_CLK_PERIOD_NS;
    localparam int SWC_STRAP_SETTLE_CYC = 4;
    localparam int SWC_CMD_BITS = 9;
    localparam int SWC_WORD_BITS = 16;

    ////////////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [15:0] ctrl_one;
        logic [15:0] ctrl_two;
        logic [15:0] xcvr;
    } swc_regs_t;

    typedef struct packed {
        logic storm_guard;
        logic duplex_full;
        logic rate_10m;
        logic pause_on;
        logic port_on;
        logic collision_discard;
        logic [1:0] lookup_algo_sel;
        logic crc_first_level;
        logic [1:0] age_sel;
        logic aging_on;
        logic forward_everything;
        logic capped_backoff;
        logic odd_nway;
        logic port7_fibre;
        logic port7_fibre_full;
        logic even_nway;
        logic port6_fibre;
        logic port6_fibre_full;
        logic far_end_fault_on;
        logic power_save_nway;
        logic auto_crossover_on;
    } swc_mode_t;

    localparam swc_regs_t SWC_REGS_RST = '{ctrl_one: SWC_CTRL_ONE_RST, ctrl_two: SWC_CTRL_TWO_RST,
                                           xcvr: SWC_XCVR_RST};

    function automatic swc_mode_t swc_decode(input swc_regs_t r);
        swc_mode_t m;
        logic [1:0] odd;
        logic [1:0] even;
        logic force_mode;
        odd = r.xcvr[SWC_ODD_LSB +: 2];
        even = r.xcvr[SWC_EVEN_LSB +: 2];
        force_mode = r.xcvr[SWC_FORCE_BIT];
        m.storm_guard = r.ctrl_one[SWC_STORM_BIT];
        m.duplex_full = r.ctrl_two[SWC_DUPLEX_BIT];
        m.rate_10m = r.ctrl_two[SWC_RATE_BIT];
        m.pause_on = r.ctrl_two[SWC_PAUSE_BIT];
        m.port_on = r.ctrl_two[SWC_PORT_ON_BIT];
        m.collision_discard = r.ctrl_two[SWC_DISCARD_BIT];
        m.lookup_algo_sel = r.ctrl_two[SWC_HASH_LSB +: 2];
        m.crc_first_level = (r.ctrl_two[SWC_HASH_LSB +: 2] == SWC_HASH_CRC_CRC);
        m.age_sel = r.ctrl_two[SWC_AGE_LSB +: 2];
        m.aging_on = (r.ctrl_two[SWC_AGE_LSB +: 2] != SWC_AGE_NONE);
        m.forward_everything = r.ctrl_two[SWC_FWD_ALL_BIT];
        m.capped_backoff = r.ctrl_two[SWC_BACKOFF_BIT];
        m.odd_nway = !force_mode && (odd == SWC_OPT_NWAY);
        m.port7_fibre = !force_mode && (odd == SWC_OPT_FX_FULL || odd == SWC_OPT_FX_HALF);
        m.port7_fibre_full = !force_mode && (odd == SWC_OPT_FX_FULL);
        m.even_nway = !force_mode && (even == SWC_OPT_NWAY);
        m.port6_fibre = !force_mode && (even == SWC_OPT_FX_FULL || even == SWC_OPT_FX_HALF);
        m.port6_fibre_full = !force_mode && (even == SWC_OPT_FX_FULL);
        m.far_end_fault_on = r.xcvr[SWC_FEF_BIT];
        m.power_save_nway = r.xcvr[SWC_SAVE_PW_BIT];
        m.auto_crossover_on = r.xcvr[SWC_XOVER_BIT];
        return m;
    endfunction : swc_decode

    localparam swc_mode_t SWC_MODE_RST = swc_decode(SWC_REGS_RST);

    typedef enum logic [2:0] {
        RD_IDLE = 3'h1,
        RD_SEND = 3'h2,
        RD_RECV = 3'h4
    } swc_rd_state_t;

    typedef enum logic [3:0] {
        LD_STRAP = 4'h1,
        LD_SIG = 4'h2,
        LD_REGS = 4'h4,
        LD_DONE = 4'h8
    } swc_ld_state_t;

endpackage : swc_pkg

/* src/swc_eeprom_rd.sv */
// Reads one 16-bit word from a three-wire serial EEPROM.
// Assumes the EEPROM samples data-in on the rising serial clock and drives data-out after it.
`timescale 1ns/100ps
module swc_eeprom_rd
    import swc_pkg::*;
#(
    parameter int SK_HALF = SWC_SK_HALF_CYC
) (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    input wire logic [5:0] addr_in,
    output logic done_out,
    output logic [15:0] data_out,
    output logic eep_cs_out,
    output logic eep_sk_out,
    output logic eep_di_out,
    input wire logic eep_do_in
);

    // Data-out passes two sync stages, so the high phase must outlast them
    initial begin
        if (SK_HALF < 4 || SK_HALF > 255) begin
            $error("SK_HALF out of range");
        end
    end

    typedef struct packed {
        swc_rd_state_t st;
        logic [7:0] cnt;
        logic [4:0] bits;
        logic [8:0] tx;
        logic [15:0] rx;
        logic cs;
        logic sk;
        logic di;
        logic done;
        logic [15:0] data;
        logic sync_a;
        logic sync_b;
    } swc_read_t;

    localparam logic [7:0] HALF_LAST = 8'(SK_HALF - 1);
    localparam logic [4:0] CMD_BITS = 5'(SWC_CMD_BITS);
    localparam logic [4:0] WORD_BITS = 5'(SWC_WORD_BITS);

    swc_read_t s_reg;
    swc_read_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.sync_a = eep_do_in;
        s_next.sync_b = s_reg.sync_a;
        case (s_reg.st)
            RD_IDLE: begin
                if (start_in) begin
                    s_next.st = RD_SEND;
                    s_next.tx = {SWC_READ_CMD, addr_in};
                    s_next.di = SWC_READ_CMD[2];
                    s_next.cs = 1'b1;
                    s_next.sk = 1'b0;
                    s_next.cnt = 8'h00;
                    s_next.bits = CMD_BITS;
                end
            end
            RD_SEND, RD_RECV: begin
                s_next.cnt = s_reg.cnt + 8'h01;
                if (s_reg.cnt == HALF_LAST) begin
                    s_next.cnt = 8'h00;
                    s_next.sk = !s_reg.sk;
                    if (s_reg.sk) begin
                        s_next.bits = s_reg.bits - 5'h01;
                        if (s_reg.st == RD_SEND) begin
                            s_next.tx = {s_reg.tx[7:0], 1'b0};
                            s_next.di = s_reg.tx[7];
                            if (s_reg.bits == 5'h01) begin
                                s_next.st = RD_RECV;
                                s_next.bits = WORD_BITS;
                                s_next.di = 1'b0;
                            end
                        end else begin
                            // Sample at the end of the high phase, most significant bit first
                            s_next.rx = {s_reg.rx[14:0], s_reg.sync_b};
                            if (s_reg.bits == 5'h01) begin
                                s_next.st = RD_IDLE;
                                s_next.data = {s_reg.rx[14:0], s_reg.sync_b};
                                s_next.done = 1'b1;
                                s_next.cs = 1'b0;
                            end
                        end
                    end
                end
            end
            default: begin
                s_next.st = RD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_reg <= '{st: RD_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign done_out = s_reg.done;
    assign data_out = s_reg.data;
    assign eep_cs_out = s_reg.cs;
    assign eep_sk_out = s_reg.sk;
    assign eep_di_out = s_reg.di;

endmodule : swc_eeprom_rd

/* src/swc_top.sv */
// Configuration bank of the switch: strap capture, EEPROM load and decoded settings.
// Assumes strap pins are stable around reset release and a serial EEPROM may be absent
// (its data-out then reads zero or one, never the signature).
`timescale 1ns/100ps

module swc_top
    import swc_pkg::*;
#(
    parameter int SK_HALF = SWC_SK_HALF_CYC
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire swc_regs_t strap_in,
    input wire logic eep_do_in,
    output logic eep_cs_out,
    output logic eep_sk_out,
    output logic eep_di_out,
    output swc_regs_t regs_out,
    output swc_mode_t mode_out,
    output logic eeprom_valid_out,
    output logic load_done_out
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reset release
    logic rst_a_reg;
    logic rst_n_reg;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_a_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_a_reg <= 1'b1;
            rst_n_reg <= rst_a_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Load state
    typedef struct packed {
        swc_ld_state_t st;
        logic [3:0] settle;
        logic [1:0] idx;
        logic rd_start;
        logic [5:0] rd_addr;
        swc_regs_t strap_a;
        swc_regs_t strap_b;
        swc_regs_t regs;
        swc_mode_t mode;
        logic valid;
        logic done;
    } swc_load_t;

    localparam logic [3:0] SETTLE_LAST = 4'(SWC_STRAP_SETTLE_CYC - 1);
    localparam logic [1:0] LAST_IDX = 2'h2;

    swc_load_t s_reg;
    swc_load_t s_next;
    logic rd_done;
    logic [15:0] rd_data;

    // Option fields of the transceiver word
    logic forced;
    logic [1:0] odd_opt;
    logic [1:0] even_opt;

    assign forced = s_reg.regs.xcvr[SWC_FORCE_BIT];
    assign odd_opt = s_reg.regs.xcvr[SWC_ODD_LSB +: 2];
    assign even_opt = s_reg.regs.xcvr[SWC_EVEN_LSB +: 2];

    swc_eeprom_rd #(
        .SK_HALF(SK_HALF)
    ) u_rd (
        .ref_clk_in(ref_clk_in),
        .rst_n_in(rst_n_reg),
        .start_in(s_reg.rd_start),
        .addr_in(s_reg.rd_addr),
        .done_out(rd_done),
        .data_out(rd_data),
        .eep_cs_out(eep_cs_out),
        .eep_sk_out(eep_sk_out),
        .eep_di_out(eep_di_out),
        .eep_do_in(eep_do_in)
    );

    function automatic swc_regs_t masked(input swc_regs_t r);
        swc_regs_t m;
        m.ctrl_one = r.ctrl_one & SWC_CTRL_ONE_MASK;
        m.ctrl_two = r.ctrl_two & SWC_CTRL_TWO_MASK;
        m.xcvr = r.xcvr & SWC_XCVR_MASK;
        return m;
    endfunction : masked

    always_comb begin
        s_next = s_reg;
        s_next.rd_start = 1'b0;
        // Strap pins are asynchronous; two stages before use
        s_next.strap_a = strap_in;
        s_next.strap_b = s_reg.strap_a;
        case (s_reg.st)
            LD_STRAP: begin
                s_next.settle = s_reg.settle + 4'h1;
                if (s_reg.settle == SETTLE_LAST) begin
                    s_next.regs = masked(s_reg.strap_b);
                    s_next.st = LD_SIG;
                    s_next.rd_start = 1'b1;
                    s_next.rd_addr = SWC_ADDR_SIG;
                end
            end
            LD_SIG: begin
                if (rd_done) begin
                    if (rd_data == SWC_SIGNATURE) begin
                        s_next.valid = 1'b1;
                        s_next.st = LD_REGS;
                        s_next.idx = 2'h0;
                        s_next.rd_start = 1'b1;
                        s_next.rd_addr = SWC_ADDR_CTRL_ONE;
                    end else begin
                        s_next.st = LD_DONE;
                    end
                end
            end
            LD_REGS: begin
                if (rd_done) begin
                    // Reserved bits of loaded words are forced to zero
                    case (s_reg.idx)
                        2'h0: s_next.regs.ctrl_one = rd_data & SWC_CTRL_ONE_MASK;
                        2'h1: s_next.regs.ctrl_two = rd_data & SWC_CTRL_TWO_MASK;
                        default: s_next.regs.xcvr = rd_data & SWC_XCVR_MASK;
                    endcase
                    if (s_reg.idx == LAST_IDX) begin
                        s_next.st = LD_DONE;
                    end else begin
                        s_next.idx = s_reg.idx + 2'h1;
                        s_next.rd_start = 1'b1;
                        s_next.rd_addr = (s_reg.idx == 2'h0) ? SWC_ADDR_CTRL_TWO : SWC_ADDR_XCVR;
                    end
                end
            end
            LD_DONE: begin
                // lookup selection frozen once loading ends
                s_next.done = 1'b1;
                if (!s_reg.done) begin
                    s_next.mode.storm_guard = s_reg.regs.ctrl_one[SWC_STORM_BIT];
                    s_next.mode.duplex_full = s_reg.regs.ctrl_two[SWC_DUPLEX_BIT];
                    s_next.mode.rate_10m = s_reg.regs.ctrl_two[SWC_RATE_BIT];
                    s_next.mode.pause_on = s_reg.regs.ctrl_two[SWC_PAUSE_BIT];
                    s_next.mode.port_on = s_reg.regs.ctrl_two[SWC_PORT_ON_BIT];
                    s_next.mode.collision_discard = s_reg.regs.ctrl_two[SWC_DISCARD_BIT];
                    s_next.mode.lookup_algo_sel = s_reg.regs.ctrl_two[SWC_HASH_LSB +: 2];
                    s_next.mode.crc_first_level = (s_reg.regs.ctrl_two[SWC_HASH_LSB +: 2] == SWC_HASH_CRC_CRC);
                    s_next.mode.age_sel = s_reg.regs.ctrl_two[SWC_AGE_LSB +: 2];
                    s_next.mode.aging_on = (s_reg.regs.ctrl_two[SWC_AGE_LSB +: 2] != SWC_AGE_NONE);
                    s_next.mode.forward_everything = s_reg.regs.ctrl_two[SWC_FWD_ALL_BIT];
                    s_next.mode.capped_backoff = s_reg.regs.ctrl_two[SWC_BACKOFF_BIT];
                    s_next.mode.odd_nway = !forced && (odd_opt == SWC_OPT_NWAY);
                    s_next.mode.port7_fibre = !forced && (odd_opt == SWC_OPT_FX_FULL || odd_opt == SWC_OPT_FX_HALF);
                    s_next.mode.port7_fibre_full = !forced && (odd_opt == SWC_OPT_FX_FULL);
                    s_next.mode.even_nway = !forced && (even_opt == SWC_OPT_NWAY);
                    s_next.mode.port6_fibre = !forced && (even_opt == SWC_OPT_FX_FULL || even_opt == SWC_OPT_FX_HALF);
                    s_next.mode.port6_fibre_full = !forced && (even_opt == SWC_OPT_FX_FULL);
                    s_next.mode.far_end_fault_on = s_reg.regs.xcvr[SWC_FEF_BIT];
                    s_next.mode.power_save_nway = s_reg.regs.xcvr[SWC_SAVE_PW_BIT];
                    s_next.mode.auto_crossover_on = s_reg.regs.xcvr[SWC_XOVER_BIT];
                end
            end
            default: begin
                s_next.st = LD_STRAP;
            end
        endcase
    end

    // Mode holds its reset defaults until loading completes, then changes once
    always_ff @(posedge ref_clk_in or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            s_reg <= '{st: LD_STRAP, settle: 4'h0, idx: 2'h0, rd_start: 1'b0, rd_addr: 6'h00,
                       strap_a: SWC_REGS_RST, strap_b: SWC_REGS_RST, regs: SWC_REGS_RST,
                       mode: SWC_MODE_RST, valid: 1'b0, done: 1'b0};
        end else begin
            s_reg <= s_next;
        end
    end

    assign regs_out = s_reg.regs;
    assign mode_out = s_reg.mode;
    assign eeprom_valid_out = s_reg.valid;
    assign load_done_out = s_reg.done;

endmodule : swc_top

/* verification/swc_eeprom_model.sv */
// Behavioural three-wire serial EEPROM holding the words the bank reads.
// Assumes read command 1,1,0 plus six address bits, taken on rising serial clock.
`timescale 1ns/100ps
module swc_eeprom_model (
    input wire logic cs_in,
    input wire logic sk_in,
    input wire logic di_in,
    output logic do_out,
    input wire logic [15:0] sig_in,
    input wire logic [15:0] w2_in,
    input wire logic [15:0] w3_in,
    input wire logic [15:0] w4_in
);
    logic [4:0] n = 5'h00;
    logic [5:0] adr = 6'h00;
    logic [15:0] word;
    initial do_out = 1'b0;
    always_comb begin
        case (adr)
            6'h00: word = sig_in;
            6'h02: word = w2_in;
            6'h03: word = w3_in;
            6'h04: word = w4_in;
            default: word = 16'h0000;
        endcase
    end
    ////////////////////////////////////////
    // Released line flips, so a stale bit never reads as good data
    always @(posedge sk_in or negedge cs_in) begin
        if (!cs_in) begin
            n <= 5'h00;
            do_out <= #1 ~do_out;
        end else begin
            n <= n + 5'h01;
            if (n >= 5'h03 && n <= 5'h08) begin
                adr <= {adr[4:0], di_in};
            end
            if (n == 5'h08) begin
                do_out <= #1 1'b0;
            end else if (n >= 5'h09 && n <= 5'h18) begin
                do_out <= #1 word[5'h18 - n];
            end
        end
    end
endmodule : swc_eeprom_model

/* verification/swc_top_asserts.sv */
// Checker for the configuration bank, watching only the top-level ports.
// Assumes it is bound to every swc_top instance.
`timescale 1ns/100ps
module swc_top_asserts
    import swc_pkg::*;
#(
    parameter int SK_HALF = SWC_SK_HALF_CYC
) (
    input wire logic ref_clk_in,
    input wire logic nrst_in,
    input wire swc_regs_t strap_in,
    input wire logic eep_do_in,
    input wire logic eep_cs_out,
    input wire logic eep_sk_out,
    input wire logic eep_di_out,
    input wire swc_regs_t regs_out,
    input wire swc_mode_t mode_out,
    input wire logic eeprom_valid_out,
    input wire logic load_done_out
);
    wire logic d = load_done_out;
    wire logic [15:0] c2 = regs_out.ctrl_two;
    wire logic [15:0] xv = regs_out.xcvr;
    wire logic fm = regs_out.xcvr[11];
    swc_mode_t m;
    assign m = mode_out;
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////
    storm_map_a: assert property (
        d |-> m.storm_guard == regs_out.ctrl_one[2]) else $error("storm bit");
    port_bits_a: assert property (
        d |-> {m.duplex_full, m.rate_10m, m.pause_on, m.port_on} == c2[12:9]) else $error("port bits");
    discard_map_a: assert property (
        d |-> m.collision_discard == c2[7]) else $error("discard bit");
    algo_map_a: assert property (
        d |-> m.lookup_algo_sel == c2[6:5] && m.crc_first_level == (c2[6:5] == 2'h2)) else $error("hash select");
    mode_held_a: assert property (
        !d |-> m == SWC_MODE_RST) else $error("mode before load");
    aging_map_a: assert property (
        d |-> m.age_sel == c2[4:3] && m.aging_on == (c2[4:3] != 2'h0)) else $error("aging field");
    fwd_map_a: assert property (
        d |-> m.forward_everything == c2[2]) else $error("forward bit");
    backoff_map_a: assert property (
        d |-> m.capped_backoff == c2[1]) else $error("backoff bit");
    odd_opt_a: assert property (
        d |-> {m.odd_nway, m.port7_fibre, m.port7_fibre_full} ==
        {!fm && xv[15:14] == 2'h0, !fm && xv[15], !fm && xv[15:14] == 2'h2}) else $error("odd option");
    even_opt_a: assert property (
        d |-> {m.even_nway, m.port6_fibre, m.port6_fibre_full} ==
        {!fm && xv[13:12] == 2'h0, !fm && xv[13], !fm && xv[13:12] == 2'h2}) else $error("even option");
    xcvr_bits_a: assert property (
        d |-> {m.far_end_fault_on, m.power_save_nway, m.auto_crossover_on} == xv[10:8])
        else $error("transceiver bits");
    image_stands_a: assert property (
        d && $past(d) |-> $stable({regs_out, mode_out, eeprom_valid_out})) else $error("image moved");
    sk_frame_a: assert property (
        !eep_cs_out |-> !eep_sk_out) else $error("clock outside frame");
    cover property ($rose(eeprom_valid_out));
    cover property ($rose(d) && !eeprom_valid_out);
    cover property (d && m.port6_fibre_full);
endmodule : swc_top_asserts

bind swc_top swc_top_asserts #(.SK_HALF(SK_HALF)) i_chk (.ref_clk_in(ref_clk_in), .nrst_in(nrst_in),
    .strap_in(strap_in), .eep_do_in(eep_do_in), .eep_cs_out(eep_cs_out), .eep_sk_out(eep_sk_out),
    .eep_di_out(eep_di_out), .regs_out(regs_out), .mode_out(mode_out), .eeprom_valid_out(eeprom_valid_out),
    .load_done_out(load_done_out));

/* verification/switch_config_registers_bench.sv */
// Bench for the configuration bank: reset values, strap and EEPROM load cases.
// Assumes the EEPROM model beside it and the checker bound to swc_top.
`timescale 1ns/100ps
module switch_config_registers_bench
    import swc_pkg::*;
;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    swc_regs_t strap = '0;
    logic [15:0] sig = '0, w2 = '0, w3 = '0, w4 = '0;
    logic eep_do, eep_cs, eep_sk, eep_di, valid, done;
    swc_regs_t regs;
    swc_mode_t mode;
    int miscompares = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [15:0] w3t [4] = '{16'h0000, 16'h0028, 16'h0050, 16'h0078};
    logic [15:0] w4t [4] = '{16'h2100, 16'hB000, 16'hC000, 16'h5000};
    logic [12:0] expt [4] = '{13'h108C, 13'h0169, 13'h0253, 13'h0301};
    always #5 ref_clk = ~ref_clk;

    // Short serial clock keeps each load under a thousand cycles
    swc_top #(.SK_HALF(4)) i_dut (.ref_clk_in(ref_clk), .nrst_in(nrst), .strap_in(strap), .eep_do_in(eep_do),
        .eep_cs_out(eep_cs), .eep_sk_out(eep_sk), .eep_di_out(eep_di), .regs_out(regs), .mode_out(mode),
        .eeprom_valid_out(valid), .load_done_out(done));
    swc_eeprom_model i_eep (.cs_in(eep_cs), .sk_in(eep_sk), .di_in(eep_di), .do_out(eep_do), .sig_in(sig),
        .w2_in(w2), .w3_in(w3), .w4_in(w4));
    ////////////////////////////////////////
    task automatic conclude;
        $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task automatic cmp(input logic [48:0] got, input logic [48:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    // Straps held stable from before release, as the bank samples them late
    task automatic run(input logic [15:0] s, a, b, c, input swc_regs_t st);
        @(posedge ref_clk);
        #1;
        sig = s;
        w2 = a;
        w3 = b;
        w4 = c;
        strap = st;
        nrst = 1'b0;
        repeat (5) @(posedge ref_clk);
        #1;
        nrst = 1'b1;
        while (done !== 1'b1) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : run

    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            conclude();
        end
    end
    ////////////////////////////////////////
    initial begin
        repeat (2) @(posedge ref_clk);
        #1;
        cmp({valid, regs},
            {1'b0, 16'h0000, 16'h1812, 16'h0600});
        cmp(49'({mode.duplex_full, mode.rate_10m, mode.pause_on, mode.port_on, mode.capped_backoff,
            mode.far_end_fault_on, mode.power_save_nway, mode.auto_crossover_on, done}),
            49'h19C);
        $display("test reset_values done");
        run(16'hFFFF, 16'h55AA, 16'h55AA, 16'h55AA, 48'hFFFF_FFFF_FFFF);
        cmp({valid, regs}, {1'b0, 16'h0004, 16'h1EFE, 16'hFF00});
        run(16'h55AB, 16'hFFFF, 16'hFFFF, 16'hFFFF, 48'h0);
        cmp({valid, regs}, 49'h0);
        $display("test strap_only done");
        run(16'h55AA, 16'hFFFF, 16'hFFFF, 16'hFFFF, 48'h0);
        cmp({valid, regs}, {1'b1, 16'h0004, 16'h1EFE, 16'hFF00});
        cmp(49'({mode.storm_guard, mode.collision_discard, mode.forward_everything, mode.port_on,
            mode.pause_on, mode.odd_nway, mode.port7_fibre}), 49'h7C);
        $display("test eeprom_all_ones done");
        for (int i = 0; i < 4; i++) begin
            run(16'h55AA, {13'h0, i[0], 2'h0}, w3t[i], w4t[i], '1);
            cmp({valid, regs}, {1'b1, 13'h0, i[0], 2'h0, w3t[i], w4t[i]});
            cmp(49'({mode.auto_crossover_on, mode.duplex_full, mode.rate_10m, mode.lookup_algo_sel,
                mode.odd_nway, mode.port7_fibre, mode.port7_fibre_full, mode.even_nway, mode.port6_fibre,
                mode.port6_fibre_full, mode.crc_first_level, mode.aging_on}),
                49'(expt[i]));
        end
        $display("test option_table done");
        conclude();
    end
endmodule : switch_config_registers_bench
